// *** hdl/light_threshold_irq_logic.v ***
// threshold interrupt logic of a visible / ultraviolet light sensor
// assumes the serial front end presents byte register accesses as one-cycle strobes on
// sys_clk, and the converters present each finished result with a one-cycle done pulse
`timescale 1ns/1ns
`default_nettype none
`include "light_irq_map.vh"

module light_threshold_irq_logic (
    // clock and reset
    input wire sys_clk,
    input wire reset,
    // register port from the serial front end
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWrite,
    input wire regRead,
    output reg [7:0] regRdData,
    // conversion results
    input wire [19:0] visibleCount,
    input wire visibleDone,
    input wire [19:0] uvCount,
    input wire uvDone,
    // open-drain interrupt pin, driven low while pending
    output reg intPinOut,
    output reg intPinOe
);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [7:0] irqConfig_reg;
    reg [7:0] persistCountCfg_reg;
    reg [7:0] upperLow_reg;
    reg [7:0] upperMid_reg;
    reg [3:0] upperHigh_reg;
    reg [7:0] lowerLow_reg;
    reg [7:0] lowerMid_reg;
    reg [3:0] lowerHigh_reg;
    reg [3:0] runCount_reg;
    reg [3:0] runCount_next;
    reg irqFlag_reg;
    reg powerOnFlag_reg;
    reg dataNewFlag_reg;
    reg fire;
    reg [19:0] sample;
    reg evaluate;
    reg [7:0] statusByte;

    wire [19:0] upperLimit;
    wire [19:0] lowerLimit;
    wire [1:0] sourceSel;
    wire lightIrqEnable;
    wire [3:0] persist;
    wire statusRead;
    wire configTouch;
    wire outOfRange;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // one 20-bit limit from its three byte registers
    function [19:0] limit_word;
        input [3:0] highNibble;
        input [7:0] midByte;
        input [7:0] lowByte;
        begin
            limit_word = {highNibble, midByte, lowByte};
        end
    endfunction

    // a high nibble reads back with its reserved bits as zeros
    function [7:0] nibble_byte;
        input [3:0] nibble;
        begin
            nibble_byte = {4'h0, nibble};
        end
    endfunction

    assign upperLimit = limit_word(upperHigh_reg, upperMid_reg, upperLow_reg);
    assign lowerLimit = limit_word(lowerHigh_reg, lowerMid_reg, lowerLow_reg);
    assign sourceSel = irqConfig_reg[`IRQ_SOURCE_SELECT_HI:`IRQ_SOURCE_SELECT_LO];
    assign lightIrqEnable = irqConfig_reg[`LIGHT_IRQ_ENABLE_BIT];
    assign persist = persistCountCfg_reg[`PERSIST_HI:`PERSIST_LO];
    assign statusRead = regRead && (regAddr == `STATUS_OFS);
    // only a change of the select or enable bits restarts the run
    assign configTouch = regWrite && (regAddr == `IRQ_CONFIG_OFS) &&
        ((regWrData[`IRQ_SOURCE_SELECT_HI:`IRQ_SOURCE_SELECT_LO] != sourceSel) ||
         (regWrData[`LIGHT_IRQ_ENABLE_BIT] != lightIrqEnable));
    assign outOfRange = (sample > upperLimit) || (sample < lowerLimit);

    // status byte built from its flag positions, reserved bits read zero
    always @* begin
        statusByte = 8'h00;
        statusByte[`STATUS_POWER_ON_BIT] = powerOnFlag_reg;
        statusByte[`STATUS_IRQ_BIT] = irqFlag_reg;
        statusByte[`STATUS_DATA_NEW_BIT] = dataNewFlag_reg;
    end

    // ----------------------------------------
    // source selection and persistence
    // ----------------------------------------
    always @* begin
        sample = 20'h00000;
        evaluate = 1'b0;
        case (sourceSel)
            `SOURCE_VISIBLE: begin
                sample = visibleCount;
                evaluate = visibleDone;
            end
            `SOURCE_UV: begin
                sample = uvCount;
                evaluate = uvDone;
            end
            default: begin
                // reserved codes evaluate nothing
                evaluate = 1'b0;
            end
        endcase
    end

    always @* begin
        runCount_next = runCount_reg;
        fire = 1'b0;
        if (configTouch) begin
            runCount_next = 4'h0;
        end else if (evaluate && lightIrqEnable) begin
            if (!outOfRange) begin
                runCount_next = 4'h0;
            end else if (runCount_reg >= persist) begin
                // saturate, so a lasting excursion fires on every further result
                fire = 1'b1;
            end else begin
                runCount_next = runCount_reg + 4'h1;
            end
        end
    end

    // ----------------------------------------
    // configuration and limit registers
    // ----------------------------------------
    always @(posedge sys_clk) begin
        if (reset) begin
            irqConfig_reg <= `IRQ_CONFIG_RESET;
            persistCountCfg_reg <= `PERSIST_COUNT_CFG_RESET;
            upperLow_reg <= `LIMIT_BYTE_ONES;
            upperMid_reg <= `LIMIT_BYTE_ONES;
            upperHigh_reg <= `LIMIT_NIBBLE_ONES;
            lowerLow_reg <= `LIMIT_BYTE_ZERO;
            lowerMid_reg <= `LIMIT_BYTE_ZERO;
            lowerHigh_reg <= `LIMIT_NIBBLE_ZERO;
        end else begin
            if (regWrite) begin
                case (regAddr)
                    `IRQ_CONFIG_OFS: irqConfig_reg <= regWrData;
                    `PERSIST_COUNT_CFG_OFS: persistCountCfg_reg <= regWrData;
                    `UPPER_LIMIT_LOW_OFS: upperLow_reg <= regWrData;
                    `UPPER_LIMIT_MID_OFS: upperMid_reg <= regWrData;
                    `UPPER_LIMIT_HIGH_OFS: upperHigh_reg <= regWrData[`LIMIT_NIBBLE_HI:0];
                    `LOWER_LIMIT_LOW_OFS: lowerLow_reg <= regWrData;
                    `LOWER_LIMIT_MID_OFS: lowerMid_reg <= regWrData;
                    `LOWER_LIMIT_HIGH_OFS: lowerHigh_reg <= regWrData[`LIMIT_NIBBLE_HI:0];
                    default: begin
                        // writes elsewhere are ignored
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // run counter and status flags
    // ----------------------------------------
    always @(posedge sys_clk) begin
        if (reset) begin
            runCount_reg <= 4'h0;
            irqFlag_reg <= 1'b0;
            powerOnFlag_reg <= 1'b1;
            dataNewFlag_reg <= 1'b0;
        end else begin
            runCount_reg <= runCount_next;
            // set wins over the clear-on-read
            if (fire) begin
                irqFlag_reg <= 1'b1;
            end else if (statusRead) begin
                irqFlag_reg <= 1'b0;
            end
            if (statusRead) begin
                powerOnFlag_reg <= 1'b0;
            end
            if (visibleDone || uvDone) begin
                dataNewFlag_reg <= 1'b1;
            end else if (statusRead) begin
                dataNewFlag_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // read data and interrupt pin
    // ----------------------------------------
    // read data stands one cycle and is zero otherwise, so a stale byte never lingers
    always @(posedge sys_clk) begin
        if (reset) begin
            regRdData <= 8'h00;
            intPinOut <= 1'b0;
            intPinOe <= 1'b0;
        end else begin
            // pin follows the pending flag one cycle late, low-active open drain
            intPinOut <= 1'b0;
            intPinOe <= irqFlag_reg;
            regRdData <= 8'h00;
            if (regRead) begin
                case (regAddr)
                    `STATUS_OFS: regRdData <= statusByte;
                    `IRQ_CONFIG_OFS: regRdData <= irqConfig_reg;
                    `PERSIST_COUNT_CFG_OFS: regRdData <= persistCountCfg_reg;
                    `UPPER_LIMIT_LOW_OFS: regRdData <= upperLow_reg;
                    `UPPER_LIMIT_MID_OFS: regRdData <= upperMid_reg;
                    `UPPER_LIMIT_HIGH_OFS: regRdData <= nibble_byte(upperHigh_reg);
                    `LOWER_LIMIT_LOW_OFS: regRdData <= lowerLow_reg;
                    `LOWER_LIMIT_MID_OFS: regRdData <= lowerMid_reg;
                    `LOWER_LIMIT_HIGH_OFS: regRdData <= nibble_byte(lowerHigh_reg);
                    default: regRdData <= 8'h00;
                endcase
            end
        end
    end

endmodule // light_threshold_irq_logic
`default_nettype wire

// *** hdl/light_irq_map.vh ***
// register offsets, field positions, reset values of the light threshold interrupt logic
// assumes byte-wide register accesses from a two-wire serial front end
`ifndef LIGHT_IRQ_MAP_VH
`define LIGHT_IRQ_MAP_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define STATUS_OFS 8'h07
`define IRQ_CONFIG_OFS 8'h19
`define PERSIST_COUNT_CFG_OFS 8'h1a
`define UPPER_LIMIT_LOW_OFS 8'h21
`define UPPER_LIMIT_MID_OFS 8'h22
`define UPPER_LIMIT_HIGH_OFS 8'h23
`define LOWER_LIMIT_LOW_OFS 8'h24
`define LOWER_LIMIT_MID_OFS 8'h25
`define LOWER_LIMIT_HIGH_OFS 8'h26

// ----------------------------------------
// field positions
// ----------------------------------------
`define LIGHT_IRQ_ENABLE_BIT 2
`define IRQ_SOURCE_SELECT_HI 5
`define IRQ_SOURCE_SELECT_LO 4
`define PERSIST_HI 7
`define PERSIST_LO 4
`define LIMIT_NIBBLE_HI 3
`define STATUS_POWER_ON_BIT 5
`define STATUS_IRQ_BIT 4
`define STATUS_DATA_NEW_BIT 3

// ----------------------------------------
// codes and reset values
// ----------------------------------------
`define SOURCE_VISIBLE 2'h1
`define SOURCE_UV 2'h3
`define IRQ_CONFIG_RESET 8'h10
`define PERSIST_COUNT_CFG_RESET 8'h00
`define LIMIT_BYTE_ONES 8'hff
`define LIMIT_NIBBLE_ONES 4'hf
`define LIMIT_BYTE_ZERO 8'h00
`define LIMIT_NIBBLE_ZERO 4'h0

`endif

// *** testbench/light_irq_host.sv ***
// host model: byte writes and reads on the register port
// assumes one task call at a time, after reset release
`timescale 1ns/1ns
`default_nettype none
module light_irq_host (
    input wire sys_clk,
    input wire [7:0] regRdData,
    output logic [7:0] regAddr = 8'h00,
    output logic [7:0] regWrData = 8'h00,
    output logic regWrite = 1'b0,
    output logic regRead = 1'b0
);
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        regAddr = a;
        regWrData = d;
        regWrite = 1'b1;
        @(negedge sys_clk);
        regWrite = 1'b0;
        regWrData = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(negedge sys_clk);
        regAddr = a;
        regRead = 1'b1;
        @(negedge sys_clk);
        regRead = 1'b0;
        regAddr = ~a;
        // raw register bytes only; lux or index scaling is host software arithmetic
        q = regRdData;
    endtask
endmodule // light_irq_host
`default_nettype wire

// *** testbench/light_irq_asserts.sv ***
// port timing checks of the light threshold interrupt logic
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module light_irq_asserts (
    input wire sys_clk, input wire reset, input wire [7:0] regAddr, input wire regWrite,
    input wire regRead, input wire [7:0] regRdData, input wire visibleDone,
    input wire uvDone, input wire intPinOut, input wire intPinOe
);
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (reset);
    wire rdSt = regRead && regAddr == 8'h07;
    // no write since reset: reads must still show defaults
    logic anyWr;
    always @(posedge sys_clk) anyWr <= !reset && (anyWr || regWrite);
    a_read_one_cycle: assert property (!regRead |=> regRdData == 8'h00)
        else $error("read data outlived its cycle");
    a_status_reserved: assert property (rdSt |=> regRdData[2:0] == 3'h0 && !regRdData[7:6])
        else $error("status reserved bits set");
    a_cfg_default: assert property (regRead && !anyWr && regAddr == 8'h19 |=>
        regRdData == 8'h10) else $error("config default wrong");
    a_upper_default: assert property (regRead && !anyWr && regAddr == 8'h23 |=>
        regRdData == 8'h0f) else $error("upper limit default wrong");
    a_pin_low: assert property (intPinOut == 1'b0)
        else $error("interrupt pin driven high");
    a_pin_rise: assert property ($rose(intPinOe) |-> $past(visibleDone || uvDone, 2))
        else $error("interrupt without conversion");
    a_pin_fall: assert property ($fell(intPinOe) && !$past(reset) |-> $past(rdSt, 2))
        else $error("interrupt dropped without status read");
    a_pin_holds: assert property (intPinOe && !rdSt && !$past(rdSt) |=> intPinOe)
        else $error("interrupt did not hold");
endmodule // light_irq_asserts
bind light_threshold_irq_logic light_irq_asserts chk (.sys_clk(sys_clk), .reset(reset),
    .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .visibleDone(visibleDone), .uvDone(uvDone), .intPinOut(intPinOut), .intPinOe(intPinOe));
`default_nettype wire

// *** testbench/tb_light_threshold_irq_logic.sv ***
// self-checking bench of the light threshold interrupt logic
// assumes the host model drives the register port; conversions come from here
`timescale 1ns/1ns
`default_nettype none
module tb_light_threshold_irq_logic;
    logic sys_clk = 1'b0, reset = 1'b1, visibleDone = 1'b0, uvDone = 1'b0;
    logic [19:0] visibleCount = 20'h00000, uvCount = 20'h00000;
    wire [7:0] regAddr, regWrData, regRdData;
    wire regWrite, regRead, intPinOut, intPinOe;
    int bad_count = 0, samples_checked = 0, cycles = 0;
    logic [7:0] q;
    light_threshold_irq_logic dut (.sys_clk(sys_clk), .reset(reset), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .visibleCount(visibleCount), .visibleDone(visibleDone), .uvCount(uvCount),
        .uvDone(uvDone), .intPinOut(intPinOut), .intPinOe(intPinOe));
    light_irq_host host (.sys_clk(sys_clk), .regRdData(regRdData), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead));
    initial forever #25 sys_clk = ~sys_clk;
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic pin(input logic e);
        chk("intPinOe", {7'h00, e}, {7'h00, intPinOe});
        chk("intPinOut", 8'h00, {7'h00, intPinOut});
    endtask
    task automatic stop_test();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // one finished conversion with the other channel in range, then a cycle for the pin
    task automatic conv(input logic uv, input logic [19:0] v);
        @(negedge sys_clk);
        uvCount = uv ? v : 20'h00080;
        visibleCount = uv ? 20'h00080 : v;
        {uvDone, visibleDone} = {uv, !uv};
        @(negedge sys_clk);
        {uvDone, visibleDone} = 2'b00;
        {uvCount, visibleCount} = {~v, ~v};
        @(negedge sys_clk);
    endtask
    task automatic t_defaults();
        logic [7:0] ofs [10] = '{8'h07, 8'h19, 8'h1a, 8'h21, 8'h22,
            8'h23, 8'h24, 8'h25, 8'h26, 8'h07};
        logic [7:0] dfl [10] = '{8'h20, 8'h10, 8'h00, 8'hff, 8'hff,
            8'h0f, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 10; i++) begin
            host.rd(ofs[i], q);
            chk("default", dfl[i], q);
        end
        host.rd(8'h00, q);
        chk("unmapped", 8'h00, q);
    endtask
    task automatic t_persist();
        host.wr(8'h21, 8'h00);
        host.wr(8'h22, 8'h01);
        host.wr(8'h23, 8'h00);
        host.wr(8'h24, 8'h10);
        host.wr(8'h1a, 8'h10);
        host.wr(8'h19, 8'h14);
        conv(0, 20'h00101);
        pin(0);
        conv(0, 20'h00100);
        conv(0, 20'h00101);
        pin(0);
        conv(0, 20'h00101);
        pin(1);
        host.rd(8'h07, q);
        chk("status", 8'h18, q);
        @(negedge sys_clk);
        pin(0);
        host.wr(8'h1a, 8'hf0);
        conv(0, 20'h00050);
        for (int i = 0; i < 16; i++) begin
            conv(0, 20'h0000f);
            pin(i == 15);
        end
        host.rd(8'h07, q);
        chk("status", 8'h18, q);
    endtask
    task automatic t_select();
        logic [7:0] cfg [5] = '{8'h04, 8'h14, 8'h24, 8'h34, 8'h30};
        host.wr(8'h1a, 8'h00);
        for (int i = 0; i < 5; i++) begin
            host.wr(8'h19, cfg[i]);
            conv(1, 20'h0000f);
            pin(i == 3);
            host.rd(8'h07, q);
            chk("status", (i == 3) ? 8'h18 : 8'h08, q);
        end
    endtask
    // the run survives a same-value rewrite and restarts on an enable or select change
    task automatic t_restart();
        host.wr(8'h1a, 8'h10);
        host.wr(8'h19, 8'h14);
        conv(0, 20'h00200);
        pin(0);
        host.wr(8'h19, 8'h14);
        conv(0, 20'h00200);
        pin(1);
        host.rd(8'h07, q);
        chk("status", 8'h18, q);
        host.wr(8'h19, 8'h10);
        host.wr(8'h19, 8'h14);
        conv(0, 20'h00200);
        pin(0);
        host.wr(8'h19, 8'h34);
        conv(1, 20'h00200);
        pin(0);
        host.rd(8'h07, q);
        chk("status", 8'h08, q);
    endtask
    // a second power-on in mid-run brings every threshold setting back
    task automatic t_power_on();
        @(negedge sys_clk);
        reset = 1'b1;
        repeat (2) @(negedge sys_clk);
        reset = 1'b0;
        pin(0);
        t_defaults();
    endtask
    initial begin
        repeat (2) @(negedge sys_clk);
        reset = 1'b0;
        t_defaults();
        t_persist();
        t_select();
        t_restart();
        t_power_on();
        stop_test();
    end
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            bad_count++;
            stop_test();
        end
    end
endmodule // tb_light_threshold_irq_logic
`default_nettype wire
